//--- mft_pkg.sv
// Package for the multifunction totalizer and digital I/O block.
// Holds register offsets, field positions, reset values and widths shared by the top, the checker and the bench.
package mft_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int CNT_W = 26;
   localparam int PORT_W = 8;
   localparam int DAC_W = 16;
   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_COUNT = 4'h1;
   localparam logic [3:0] OFF_PORT0_OUT = 4'h2;
   localparam logic [3:0] OFF_PORT1_OUT = 4'h3;
   localparam logic [3:0] OFF_PORT0_IN = 4'h4;
   localparam logic [3:0] OFF_PORT1_IN = 4'h5;
   localparam logic [3:0] OFF_WORD_IN = 4'h6;
   localparam logic [3:0] OFF_DAC0 = 4'h7;
   localparam logic [3:0] OFF_DAC1 = 4'h8;
   localparam logic [3:0] OFF_STATUS = 4'h9;
   localparam logic [3:0] OFF_SCAN_CNT = 4'hA;
   localparam logic [3:0] OFF_SCAN_P0 = 4'hB;
   localparam logic [3:0] OFF_SCAN_P1 = 4'hC;
   // CTRL fields.
   localparam int CTRL_FALL_BIT = 0;
   localparam int CTRL_CLR_BIT = 1;
   localparam int CTRL_SCAN_P0_BIT = 2;
   localparam int CTRL_SCAN_P1_BIT = 3;
   localparam int CTRL_SCAN_RUN_BIT = 4;
   localparam int CTRL_SNAP_BIT = 5;
   // STATUS fields.
   localparam int STAT_GATE_BIT = 0;
   localparam int STAT_REFUSED_BIT = 1;
   localparam int STAT_WRAP_BIT = 2;
   localparam logic [7:0] PORT_OUT_RST = 8'hFF;
   localparam logic [15:0] DAC_RST = 16'h0000;
   localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
   localparam logic [31:0] REFUSED_VAL = 32'hFFFF_FFFF;
   // Timing: fastest input pulse rate against the module clock.
   localparam int CLK_HZ = 20_000_000;
   localparam int MAX_PULSE_HZ = 100_000;
   localparam int CYC_PER_PULSE = CLK_HZ / MAX_PULSE_HZ;
endpackage

//--- mft_edge_if.sv
// Interface between the input front end and the totalizer core.
// Assumes both sides run on ref_clk.
`timescale 1ns/1ps
`default_nettype none
interface mft_edge_if;
   logic cntEvent;
   logic gateOpen;
   modport front(output cntEvent, output gateOpen);
   modport core(input cntEvent, input gateOpen);
endinterface
`default_nettype wire

//--- mft_front.sv
// Synchroniser for the count input and the two gates, edge detector for the count input.
// Assumes raw pins are asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module mft_front (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic fallSel,
   input wire logic cntIn,
   input wire logic gateHi,
   input wire logic gateLowN,
   mft_edge_if.front edgeIo
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic prevIn;
   } mft_front_s;
   mft_front_s st_r, st_nxt;
   logic rise, fall;

   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = {gateLowN, gateHi, cntIn}; // [RULE11]
      st_nxt.s2 = st_r.s1;
      st_nxt.prevIn = st_r.s2[0];
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rise = st_r.s2[0] & ~st_r.prevIn;
   assign fall = ~st_r.s2[0] & st_r.prevIn;
   assign edgeIo.cntEvent = fallSel ? fall : rise; // [RULE2] [RULE11]
   assign edgeIo.gateOpen = st_r.s2[1] & ~st_r.s2[2]; // [RULE3] [RULE4] [RULE5]
endmodule
`default_nettype wire

//--- mft_top.sv
// Top of the multifunction totalizer, dual digital port and DAC code block.
// Assumes a register master on ref_clk with one-cycle strobes and no waits.
// Function
// [RULE1] 26-bit up counter, 100 kHz pulses, none lost
// [RULE2] Configurable rising or falling count edge
// [RULE3] High gate enables counting while high
// [RULE4] Low gate enables counting while low
// [RULE5] Count only when both gates enable
// [RULE6] Ports and count readable during scans
// [RULE7] Two independent 8-bit ports, in and out
// [RULE8] Outputs open-drain: pull low, release high
// [RULE9] 16-bit combined read, refused if scanned
// [RULE10] Two 16-bit DAC codes to converters
// [RULE11] Synchronise inputs, detect edges on samples
// [RULE12] Reset clears count, releases outputs
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module mft_top #(
   parameter int CNT_W = mft_pkg::CNT_W,
   parameter int PORT_W = mft_pkg::PORT_W,
   parameter int DAC_W = mft_pkg::DAC_W
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [mft_pkg::ADDR_W-1:0] regAddr,
   input wire logic [mft_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [mft_pkg::DATA_W-1:0] regRdData,
   input wire logic cntIn,
   input wire logic gateHi,
   input wire logic gateLowN,
   input wire logic [PORT_W-1:0] port0In,
   input wire logic [PORT_W-1:0] port1In,
   output logic [PORT_W-1:0] port0Out,
   output logic [PORT_W-1:0] port0Oe,
   output logic [PORT_W-1:0] port1Out,
   output logic [PORT_W-1:0] port1Oe,
   output logic [DAC_W-1:0] dac0Code,
   output logic [DAC_W-1:0] dac1Code
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic fallSel;
      logic scanP0;
      logic scanP1;
      logic scanRun;
      logic wrapped;
      logic refused;
      logic [PORT_W-1:0] out0;
      logic [PORT_W-1:0] out1;
      logic [PORT_W-1:0] in0;
      logic [PORT_W-1:0] in1;
      logic [CNT_W-1:0] snapCnt;
      logic [PORT_W-1:0] snapP0;
      logic [PORT_W-1:0] snapP1;
      logic [DAC_W-1:0] dac0;
      logic [DAC_W-1:0] dac1;
      logic [mft_pkg::DATA_W-1:0] rdData;
   } mft_top_s;
   mft_top_s st_r, st_nxt;

   mft_edge_if edgeBus();

   mft_front u_front (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .fallSel(st_r.fallSel),
      .cntIn(cntIn),
      .gateHi(gateHi),
      .gateLowN(gateLowN),
      .edgeIo(edgeBus.front)
   );

   function automatic logic [mft_pkg::DATA_W-1:0] zext(input logic [31:0] v, input int w);
      logic [31:0] m;
      m = (w >= 32) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
      return v & m;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [CNT_W-1:0] cntNext;
      logic doWr;
      cntNext = '0;
      doWr = 1'b0;
      st_nxt = st_r;
      // The count path sees one event per clock at most; the front end
      // already turns each 10 us pulse into a single-cycle event.
      cntNext = st_r.count + CNT_W'(1);
      if (edgeBus.cntEvent && edgeBus.gateOpen) begin // [RULE1] [RULE5]
         st_nxt.count = cntNext;
         if (cntNext == '0) begin
            st_nxt.wrapped = 1'b1;
         end
      end
      // Input ports are sampled every clock so both reads see fresh pins.
      st_nxt.in0 = port0In; // [RULE7]
      st_nxt.in1 = port1In;
      doWr = regWr;
      if (doWr) begin
         case (regAddr)
            mft_pkg::OFF_CTRL: begin
               st_nxt.fallSel = regWrData[mft_pkg::CTRL_FALL_BIT]; // [RULE2]
               st_nxt.scanP0 = regWrData[mft_pkg::CTRL_SCAN_P0_BIT];
               st_nxt.scanP1 = regWrData[mft_pkg::CTRL_SCAN_P1_BIT];
               st_nxt.scanRun = regWrData[mft_pkg::CTRL_SCAN_RUN_BIT];
               if (regWrData[mft_pkg::CTRL_CLR_BIT]) begin
                  st_nxt.count = '0;
                  st_nxt.wrapped = 1'b0;
               end
               // Snapshot takes the live values, so a scan reading is coherent.
               if (regWrData[mft_pkg::CTRL_SNAP_BIT]) begin // [RULE6]
                  st_nxt.snapCnt = st_r.count;
                  st_nxt.snapP0 = st_r.in0;
                  st_nxt.snapP1 = st_r.in1;
               end
            end
            mft_pkg::OFF_PORT0_OUT: st_nxt.out0 = regWrData[PORT_W-1:0];
            mft_pkg::OFF_PORT1_OUT: st_nxt.out1 = regWrData[PORT_W-1:0];
            mft_pkg::OFF_DAC0: st_nxt.dac0 = regWrData[DAC_W-1:0]; // [RULE10]
            mft_pkg::OFF_DAC1: st_nxt.dac1 = regWrData[DAC_W-1:0]; // [RULE10]
            mft_pkg::OFF_STATUS: begin
               // Write one to clear; a refusal in the same cycle is a read, not a write.
               if (regWrData[mft_pkg::STAT_REFUSED_BIT]) begin
                  st_nxt.refused = 1'b0;
               end
               if (regWrData[mft_pkg::STAT_WRAP_BIT] && st_nxt.wrapped == st_r.wrapped) begin
                  st_nxt.wrapped = 1'b0;
               end
            end
            default: ;
         endcase
      end
      st_nxt.rdData = '0;
      if (regRd) begin
         case (regAddr)
            mft_pkg::OFF_CTRL: begin
               st_nxt.rdData[mft_pkg::CTRL_FALL_BIT] = st_r.fallSel;
               st_nxt.rdData[mft_pkg::CTRL_SCAN_P0_BIT] = st_r.scanP0;
               st_nxt.rdData[mft_pkg::CTRL_SCAN_P1_BIT] = st_r.scanP1;
               st_nxt.rdData[mft_pkg::CTRL_SCAN_RUN_BIT] = st_r.scanRun;
            end
            mft_pkg::OFF_COUNT: st_nxt.rdData = zext(32'(st_r.count), CNT_W); // [RULE6]
            mft_pkg::OFF_PORT0_OUT: st_nxt.rdData = zext(32'(st_r.out0), PORT_W);
            mft_pkg::OFF_PORT1_OUT: st_nxt.rdData = zext(32'(st_r.out1), PORT_W);
            mft_pkg::OFF_PORT0_IN: st_nxt.rdData = zext(32'(st_r.in0), PORT_W); // [RULE7]
            mft_pkg::OFF_PORT1_IN: st_nxt.rdData = zext(32'(st_r.in1), PORT_W); // [RULE7]
            mft_pkg::OFF_WORD_IN: begin
               if (st_r.scanP0 || st_r.scanP1) begin // [RULE9]
                  st_nxt.rdData = mft_pkg::REFUSED_VAL;
                  st_nxt.refused = 1'b1;
               end else begin
                  st_nxt.rdData = zext(32'({st_r.in1, st_r.in0}), 2 * PORT_W); // [RULE9]
               end
            end
            mft_pkg::OFF_DAC0: st_nxt.rdData = zext(32'(st_r.dac0), DAC_W);
            mft_pkg::OFF_DAC1: st_nxt.rdData = zext(32'(st_r.dac1), DAC_W);
            mft_pkg::OFF_STATUS: begin
               st_nxt.rdData[mft_pkg::STAT_GATE_BIT] = edgeBus.gateOpen;
               st_nxt.rdData[mft_pkg::STAT_REFUSED_BIT] = st_r.refused;
               st_nxt.rdData[mft_pkg::STAT_WRAP_BIT] = st_r.wrapped;
            end
            mft_pkg::OFF_SCAN_CNT: st_nxt.rdData = zext(32'(st_r.snapCnt), CNT_W); // [RULE6]
            mft_pkg::OFF_SCAN_P0: st_nxt.rdData = zext(32'(st_r.snapP0), PORT_W);
            mft_pkg::OFF_SCAN_P1: st_nxt.rdData = zext(32'(st_r.snapP1), PORT_W);
            default: st_nxt.rdData = mft_pkg::UNMAPPED_VAL;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0; // [RULE12]
         st_r.out0 <= mft_pkg::PORT_OUT_RST; // [RULE12]
         st_r.out1 <= mft_pkg::PORT_OUT_RST;
         st_r.dac0 <= mft_pkg::DAC_RST;
         st_r.dac1 <= mft_pkg::DAC_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Open-drain: data is always zero, the enable pulls low for a zero bit.
   assign port0Out = '0; // [RULE8]
   assign port1Out = '0;
   assign port0Oe = ~st_r.out0; // [RULE8]
   assign port1Oe = ~st_r.out1; // [RULE8]
   assign dac0Code = st_r.dac0;
   assign dac1Code = st_r.dac1;
   assign regRdData = st_r.rdData;
endmodule
`default_nettype wire

//--- mft_chk.sv
// Port checks for the totalizer and digital port block.
// Assumes one clock and a master that never reads and writes at once.
`timescale 1ns/1ps
`default_nettype none
module mft_chk #(
   parameter int CNT_W = 26,
   parameter int PORT_W = 8,
   parameter int DAC_W = 16
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic [mft_pkg::ADDR_W-1:0] regAddr,
   input wire logic [mft_pkg::DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [mft_pkg::DATA_W-1:0] regRdData,
   input wire logic [PORT_W-1:0] port0In,
   input wire logic [PORT_W-1:0] port1In,
   input wire logic [PORT_W-1:0] port0Out,
   input wire logic [PORT_W-1:0] port0Oe,
   input wire logic [PORT_W-1:0] port1Out,
   input wire logic [PORT_W-1:0] port1Oe,
   input wire logic [DAC_W-1:0] dac0Code,
   input wire logic [DAC_W-1:0] dac1Code
);
   logic scanOn_r;
   // Mirrors the scan member bits, the only cause of a refused word read.
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst)
         scanOn_r <= 1'b0;
      else if (regWr && regAddr == mft_pkg::OFF_CTRL)
         scanOn_r <= |regWrData[3:2];
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   AST_OD_LOW: assert property (port0Out == '0 && port1Out == '0)
      else $error("port data not low");
   AST_RST_OE: assert property ($fell(sys_rst) |-> port0Oe == '0 && port1Oe == '0)
      else $error("pins not released after reset");
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == '0)
      else $error("read data outside its cycle");
   AST_DAC0_WR: assert property (regWr && regAddr == mft_pkg::OFF_DAC0 |=>
      dac0Code == $past(regWrData[DAC_W-1:0])) else $error("dac0 code wrong");
   AST_DAC1_HOLD: assert property (!(regWr && regAddr == mft_pkg::OFF_DAC1) |=>
      $stable(dac1Code)) else $error("dac1 code moved");
   AST_OE0_WR: assert property (regWr && regAddr == mft_pkg::OFF_PORT0_OUT |=>
      port0Oe == ~$past(regWrData[PORT_W-1:0])) else $error("port0 enable wrong");
   AST_OE1_HOLD: assert property (!(regWr && regAddr == mft_pkg::OFF_PORT1_OUT) |=>
      $stable(port1Oe)) else $error("port1 enable moved");
   AST_WORD_REF: assert property (regRd && regAddr == mft_pkg::OFF_WORD_IN && scanOn_r
      |=> regRdData == mft_pkg::REFUSED_VAL) else $error("word read not refused");
   AST_WORD_RD: assert property (regRd && regAddr == mft_pkg::OFF_WORD_IN && !scanOn_r
      |=> regRdData == {16'h0000, $past(port1In, 2), $past(port0In, 2)})
      else $error("word read wrong");
endmodule
bind mft_top mft_chk #(.CNT_W(CNT_W), .PORT_W(PORT_W), .DAC_W(DAC_W)) chk (
   .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .port0In(port0In),
   .port1In(port1In), .port0Out(port0Out), .port0Oe(port0Oe), .port1Out(port1Out),
   .port1Oe(port1Oe), .dac0Code(dac0Code), .dac1Code(dac1Code));
`default_nettype wire

//--- mft_src.sv
// External pulse source, gates and pulled-up port pins.
// Assumes the caller enters its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module mft_src (
   input wire logic ref_clk,
   input wire logic [7:0] port0Oe,
   input wire logic [7:0] port1Oe,
   output logic cntIn,
   output logic gateHi,
   output logic gateLowN,
   output logic [7:0] port0In,
   output logic [7:0] port1In
);
   logic [7:0] ext0 = 8'h00;
   initial begin
      cntIn = 1'b0;
      gateHi = 1'b0;
      gateLowN = 1'b1;
   end
   // Pull-ups win unless either side sinks the pin.
   assign port0In = ~(port0Oe | ext0);
   assign port1In = ~port1Oe;
   task automatic pulses(input int n, input int w);
      repeat (n) begin
         cntIn <= 1'b1;
         repeat (w) @(posedge ref_clk);
         cntIn <= 1'b0;
         repeat (w) @(posedge ref_clk);
      end
   endtask
endmodule
`default_nettype wire

//--- tb_multifunction_totalizer_dio.sv
// Self-checking bench for mft_top with a pulse and pin model.
// Assumes mft_chk is bound to mft_top.
`timescale 1ns/1ps
`default_nettype none
module tb_multifunction_totalizer_dio;
   logic ref_clk, sys_rst, regWr, regRd, cntIn, gateHi, gateLowN, rdSeen;
   logic [3:0] regAddr;
   logic [31:0] regWrData, regRdData, v;
   logic [7:0] port0In, port1In, port0Out, port0Oe, port1Out, port1Oe;
   logic [15:0] dac0Code, dac1Code;
   logic [31:0] expQ[$];
   int seed = 32'h2C16;
   int mismatches = 0;
   int checksDone = 0;
   int cnt = 0;
   mft_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .cntIn(cntIn), .gateHi(gateHi), .gateLowN(gateLowN), .port0In(port0In),
      .port1In(port1In), .port0Out(port0Out), .port0Oe(port0Oe), .port1Out(port1Out),
      .port1Oe(port1Oe), .dac0Code(dac0Code), .dac1Code(dac1Code));
   mft_src src (.ref_clk(ref_clk), .port0Oe(port0Oe), .port1Oe(port1Oe), .cntIn(cntIn),
      .gateHi(gateHi), .gateLowN(gateLowN), .port0In(port0In), .port1In(port1In));
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      cyc(1);
      regWr <= 1'b0;
      // One idle cycle keeps a following call from driving the strobe twice.
      cyc(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      expQ.push_back(e);
      regRd <= 1'b1;
      regAddr <= a;
      cyc(1);
      regRd <= 1'b0;
      cyc(1);
   endtask
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // Read data stand one cycle only, so they are taken mid-cycle after the strobe.
   always @(negedge ref_clk) begin
      if (rdSeen)
         chk("rdata", regRdData, expQ.pop_front());
      rdSeen = regRd;
   end
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      cyc(20000);
      mismatches++;
      report_and_stop;
   end
   initial begin
      {sys_rst, regWr, regRd, rdSeen, regAddr, regWrData} = {4'b1000, 4'h0, 32'h0};
      cyc(8);
      sys_rst <= 1'b0;
      cyc(1);
      chk("oe", {port0Oe, port1Oe, dac0Code}, 32'h0);
      rd(mft_pkg::OFF_COUNT, 32'h0);
      for (int g = 0; g < 4; g++) begin
         src.gateHi <= g[0];
         src.gateLowN <= g[1];
         cyc(4);
         src.pulses(3, 3);
         cyc(6);
         cnt += (g == 1) ? 3 : 0;
         rd(mft_pkg::OFF_COUNT, cnt);
      end
      src.gateLowN <= 1'b0;
      wr(mft_pkg::OFF_CTRL, 32'h3);
      src.pulses(4, 100);
      src.cntIn <= 1'b1;
      cyc(6);
      rd(mft_pkg::OFF_COUNT, 32'h4);
      wr(mft_pkg::OFF_CTRL, 32'h0);
      src.cntIn <= 1'b0;
      cyc(6);
      rd(mft_pkg::OFF_COUNT, 32'h4);
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         src.ext0 <= v[31:24];
         wr(mft_pkg::OFF_PORT0_OUT, 32'(v[7:0]));
         wr(mft_pkg::OFF_PORT1_OUT, 32'(v[15:8]));
         wr(mft_pkg::OFF_DAC0, v);
         wr(mft_pkg::OFF_DAC1, ~v);
         cyc(3);
         chk("oe", {port0Oe, port1Oe, 16'h0}, {~v[7:0], ~v[15:8], 16'h0});
         chk("od", {16'h0, port0Out, port1Out}, 32'h0);
         chk("dac", {dac0Code, dac1Code}, {v[15:0], ~v[15:0]});
         rd(mft_pkg::OFF_PORT0_IN, 32'(v[7:0] & ~v[31:24]));
         rd(mft_pkg::OFF_WORD_IN, {16'h0, v[15:8], v[7:0] & ~v[31:24]});
      end
      wr(mft_pkg::OFF_CTRL, 32'h14);
      rd(mft_pkg::OFF_WORD_IN, mft_pkg::REFUSED_VAL);
      rd(mft_pkg::OFF_PORT1_IN, 32'(v[15:8]));
      rd(mft_pkg::OFF_COUNT, 32'h4);
      wr(mft_pkg::OFF_CTRL, 32'h18);
      rd(mft_pkg::OFF_WORD_IN, mft_pkg::REFUSED_VAL);
      // Snapshot of count and pins, then the refusal flag and its clear.
      wr(mft_pkg::OFF_CTRL, 32'h20);
      rd(mft_pkg::OFF_SCAN_CNT, 32'h4);
      rd(mft_pkg::OFF_SCAN_P1, 32'(v[15:8]));
      rd(mft_pkg::OFF_STATUS, 32'h3);
      wr(mft_pkg::OFF_STATUS, 32'h2);
      rd(mft_pkg::OFF_STATUS, 32'h1);
      wr(mft_pkg::OFF_CTRL, 32'h0);
      rd(4'hF, mft_pkg::UNMAPPED_VAL);
      sys_rst <= 1'b1;
      cyc(2);
      sys_rst <= 1'b0;
      cyc(1);
      chk("oe", {port0Oe, port1Oe, 16'h0}, 32'h0);
      rd(mft_pkg::OFF_COUNT, 32'h0);
      cyc(3);
      report_and_stop;
   end
endmodule
`default_nettype wire
